// file: src/elc_cfg.svh
/*
 * Constants of the E1 loopback, time-slot-zero and data link control block:
 * register offsets, field positions, readback masks and time slot numbers.
 * Assumes an 8-bit register address and 8-bit register data.
 */
`ifndef ELC_CFG_SVH
`define ELC_CFG_SVH

// ============================================================
// Register offsets
`define ELC_OFS_SIG_CTL 8'h14
`define ELC_OFS_LOOP_CTL 8'h15
`define ELC_OFS_NFAS_CTL 8'h16
`define ELC_OFS_MFDL_SEL 8'h17
`define ELC_OFS_AUX_CTL 8'h1F

// ============================================================
// Field positions
`define ELC_B_PAY_LB 0
`define ELC_B_BP_LB 1
`define ELC_B_REMOTE_LB 2
`define ELC_B_NFAS_ONLY 6
`define ELC_B_ALARM 5
`define ELC_F_NAT_HI 4
`define ELC_F_NAT_LO 0
`define ELC_B_RX_MULTIFRAME_PULSE_SELECT 6
`define ELC_F_DL_HI 4
`define ELC_F_DL_LO 0
`define ELC_B_CCS 5
`define ELC_B_AUTO_REMOTE_ALARM_CTL 0
`define ELC_B_TRSP 1

// ============================================================
// Readback masks and reset value
`define ELC_MASK_SIG 8'h20
`define ELC_MASK_LOOP 8'h07
`define ELC_MASK_NFAS 8'h7F
`define ELC_MASK_MFDL 8'h5F
`define ELC_MASK_AUX 8'h03
`define ELC_REG_RESET 8'h00

// ============================================================
// Frame layout
`define ELC_TS_ALIGN 5'h00
`define ELC_TS_SIG 5'h10
`define ELC_BIT_FIRST 3'h0
`define ELC_BIT_ALARM 3'h2
`define ELC_BIT_SA4 3'h3
`define ELC_BIT_LAST 3'h7
`define ELC_DL_TRANSPARENT 5'h10

`endif

// file: src/elc_pkg.sv
/*
 * Shared types of the E1 loopback and time-slot-zero control block.
 * Assumes elc_cfg.svh supplies the numeric constants.
 */
`default_nettype none

package elc_pkg;

    // Source of the outgoing transmit bit.
    typedef enum logic [2:0] {
        ELC_SRC_BP = 3'h0,
        ELC_SRC_LOOP = 3'h1,
        ELC_SRC_SIG = 3'h3,
        ELC_SRC_FAS = 3'h2,
        ELC_SRC_NFAS = 3'h6
    } elc_src_type;

endpackage : elc_pkg

`default_nettype wire

// file: src/elc_sync2.sv
/*
 * Two flip-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous levels; each bit is synchronised alone.
 */
`default_nettype none

module elc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    // ============================================================
    // Per-bit stages
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_r;
            logic hold_r;
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_r <= 1'b0;
                    hold_r <= 1'b0;
                end else begin
                    meta_r <= async_i[gi];
                    hold_r <= meta_r;
                end
            end
            assign sync_o[gi] = hold_r;
        end
    endgenerate

endmodule : elc_sync2

`default_nettype wire

// file: src/elc_ts0_build.sv
/*
 * Combinational builder of one bit of the transmit non-frame-alignment byte
 * of time slot zero. Assumes bit index 0 is the first bit sent (position one).
 */
`default_nettype none
`include "elc_cfg.svh"

module elc_ts0_build (
    input wire logic [2:0] bit_idx_i,
    input wire logic si_bit_i,
    input wire logic alarm_bit_i,
    input wire logic [4:0] national_i,
    input wire logic [4:0] dl_sel_i,
    input wire logic dl_bit_i,
    output logic nfas_bit_o,
    output logic dl_take_o
);

    logic [2:0] sa_idx;
    logic sa_slot;

    // Positions four to eight map to field bits four down to zero.
    assign sa_idx = 3'(`ELC_BIT_LAST - bit_idx_i);
    assign sa_slot = (bit_idx_i >= `ELC_BIT_SA4);

    always_comb begin
        nfas_bit_o = 1'b1;
        dl_take_o = 1'b0;
        if (bit_idx_i == `ELC_BIT_FIRST) begin
            nfas_bit_o = si_bit_i;
        end else if (bit_idx_i == `ELC_BIT_ALARM) begin
            nfas_bit_o = alarm_bit_i;
        end else if (sa_slot) begin
            if (dl_sel_i[sa_idx]) begin
                nfas_bit_o = dl_bit_i;
                dl_take_o = 1'b1;
            end else begin
                nfas_bit_o = national_i[sa_idx];
            end
        end
    end

endmodule : elc_ts0_build

`default_nettype wire

// file: src/elc_link_ctl.sv
/*
 * E1 framer control slice: remote, backplane and payload loopbacks, receive
 * channel 0 content, time-slot-zero NFAS insertion, multiframe pulse choice
 * and spare-bit data link selection, with its control registers.
 * Assumes the framer on the same clock supplies time slot and bit counters,
 * one-cycle bit strobes, the decoded receive bit and the line encoder output,
 * with receive data already aligned to transmit timing for payload loopback.
 */
// Implementation choice: strobed register access.
// Contract
// - Remote loopback sends received line to transmit.
// - Backplane loopback connects backplane input to output.
// - Payload loopback returns all slots except zero, and except 16 under associated signalling.
// - Slot 16 looped only in common channel mode.
// - Select: channel 0 carries only NFAS byte.
// - Remote alarm ignored while automatic control zero.
// - National bits fill unselected spare positions.
// - Multiframe pulse follows signalling or CRC-4.
// - Selected spare bits carry the data link.
// - Transparent mode forces first spare bit link.
// - Unselected spare bits come from national bits.
// - Common channel mode versus associated signalling.
`default_nettype none
`include "elc_cfg.svh"

module elc_link_ctl (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic rx_line_tip_i,
    input wire logic rx_line_ring_i,
    input wire logic tx_enc_tip_i,
    input wire logic tx_enc_ring_i,
    output logic tx_line_tip_o,
    output logic tx_line_ring_o,
    input wire logic backplane_data_in_i,
    output logic backplane_data_out_o,
    input wire logic rx_bit_en_i,
    input wire logic [4:0] rx_ts_i,
    input wire logic [2:0] rx_bit_i,
    input wire logic rx_nfas_frame_i,
    input wire logic rx_data_bit_i,
    input wire logic tx_bit_en_i,
    input wire logic [4:0] tx_ts_i,
    input wire logic [2:0] tx_bit_i,
    input wire logic tx_nfas_frame_i,
    input wire logic tx_fas_bit_i,
    input wire logic tx_si_bit_i,
    input wire logic tx_auto_alarm_i,
    input wire logic tx_sig_bit_i,
    input wire logic dl_bit_i,
    output logic dl_take_o,
    output logic tx_data_bit_o,
    output logic tx_common_channel_mode_o,
    input wire logic rx_sig_mf_i,
    input wire logic rx_crc_mf_i,
    output logic rx_multiframe_pulse_o
);

    // ============================================================
    // Control registers
    logic [7:0] sig_ctl_r;
    logic [7:0] loop_ctl_r;
    logic [7:0] nfas_ctl_r;
    logic [7:0] mfdl_sel_r;
    logic [7:0] aux_ctl_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sig_ctl_r <= `ELC_REG_RESET;
            loop_ctl_r <= `ELC_REG_RESET;
            nfas_ctl_r <= `ELC_REG_RESET;
            mfdl_sel_r <= `ELC_REG_RESET;
            aux_ctl_r <= `ELC_REG_RESET;
        end else if (reg_wr_i) begin
            // Unimplemented bits are dropped at write so they read as zero.
            unique case (reg_addr_i)
                `ELC_OFS_SIG_CTL: sig_ctl_r <= reg_wdata_i & `ELC_MASK_SIG;
                `ELC_OFS_LOOP_CTL: loop_ctl_r <= reg_wdata_i & `ELC_MASK_LOOP;
                `ELC_OFS_NFAS_CTL: nfas_ctl_r <= reg_wdata_i & `ELC_MASK_NFAS;
                `ELC_OFS_MFDL_SEL: mfdl_sel_r <= reg_wdata_i & `ELC_MASK_MFDL;
                `ELC_OFS_AUX_CTL: aux_ctl_r <= reg_wdata_i & `ELC_MASK_AUX;
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // Register read port
    logic [7:0] rd_nxt;

    always_comb begin
        rd_nxt = 8'h00;
        unique case (reg_addr_i)
            `ELC_OFS_SIG_CTL: rd_nxt = sig_ctl_r;
            `ELC_OFS_LOOP_CTL: rd_nxt = loop_ctl_r;
            `ELC_OFS_NFAS_CTL: rd_nxt = nfas_ctl_r;
            `ELC_OFS_MFDL_SEL: rd_nxt = mfdl_sel_r;
            `ELC_OFS_AUX_CTL: rd_nxt = aux_ctl_r;
            default: rd_nxt = 8'h00;
        endcase
    end

    // Read data stand for exactly the cycle after the read strobe.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_nxt;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ============================================================
    // Decoded control fields
    logic remote_line_loopback;
    logic backplane_loopback;
    logic payload_loopback;
    logic rx_nfas_only_select;
    logic tx_remote_alarm;
    logic [4:0] tx_national_bits;
    logic rx_multiframe_pulse_select;
    logic [4:0] spare_bit_link_select;
    logic tx_common_channel_mode;
    logic auto_remote_alarm_ctl;
    logic tx_transparent_mode;

    assign remote_line_loopback = loop_ctl_r[`ELC_B_REMOTE_LB];
    assign backplane_loopback = loop_ctl_r[`ELC_B_BP_LB];
    assign payload_loopback = loop_ctl_r[`ELC_B_PAY_LB];
    assign rx_nfas_only_select = nfas_ctl_r[`ELC_B_NFAS_ONLY];
    assign tx_remote_alarm = nfas_ctl_r[`ELC_B_ALARM];
    assign tx_national_bits = nfas_ctl_r[`ELC_F_NAT_HI:`ELC_F_NAT_LO];
    assign rx_multiframe_pulse_select = mfdl_sel_r[`ELC_B_RX_MULTIFRAME_PULSE_SELECT];
    assign spare_bit_link_select = mfdl_sel_r[`ELC_F_DL_HI:`ELC_F_DL_LO];
    assign tx_common_channel_mode = sig_ctl_r[`ELC_B_CCS];
    assign auto_remote_alarm_ctl = aux_ctl_r[`ELC_B_AUTO_REMOTE_ALARM_CTL];
    assign tx_transparent_mode = aux_ctl_r[`ELC_B_TRSP];

    // The rest of the transmit section reads the signalling mode here.
    assign tx_common_channel_mode_o = tx_common_channel_mode;

    // ============================================================
    // Pin synchronisers
    logic [2:0] pin_sync;
    logic rx_tip_s;
    logic rx_ring_s;
    logic bp_in_s;

    elc_sync2 #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i({rx_line_tip_i, rx_line_ring_i, backplane_data_in_i}),
        .sync_o(pin_sync)
    );

    assign rx_tip_s = pin_sync[2];
    assign rx_ring_s = pin_sync[1];
    assign bp_in_s = pin_sync[0];

    // ============================================================
    // Transmit line outputs
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_line_tip_o <= 1'b0;
            tx_line_ring_o <= 1'b0;
        end else if (remote_line_loopback) begin
            tx_line_tip_o <= rx_tip_s;
            tx_line_ring_o <= rx_ring_s;
        end else begin
            tx_line_tip_o <= tx_enc_tip_i;
            tx_line_ring_o <= tx_enc_ring_i;
        end
    end

    // ============================================================
    // Receive NFAS byte capture for backplane channel 0
    logic [7:0] rx_ts0_shift_r;
    logic [7:0] rx_nfas_byte_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_ts0_shift_r <= 8'h00;
        end else if (rx_bit_en_i && rx_ts_i == `ELC_TS_ALIGN) begin
            rx_ts0_shift_r <= {rx_ts0_shift_r[6:0], rx_data_bit_i};
        end
    end

    // The stored byte only changes after a complete NFAS slot was seen.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_nfas_byte_r <= 8'h00;
        end else if (rx_bit_en_i && rx_ts_i == `ELC_TS_ALIGN && rx_nfas_frame_i
                     && rx_bit_i == `ELC_BIT_LAST) begin
            rx_nfas_byte_r <= {rx_ts0_shift_r[6:0], rx_data_bit_i};
        end
    end

    // ============================================================
    // Backplane output
    logic bp_out_nxt;

    always_comb begin
        bp_out_nxt = rx_data_bit_i;
        if (backplane_loopback) begin
            bp_out_nxt = bp_in_s;
        end else if (rx_ts_i == `ELC_TS_ALIGN && rx_nfas_only_select) begin
            // Bit 0 of the counter is the first bit, the byte's MSB.
            bp_out_nxt = rx_nfas_byte_r[3'(`ELC_BIT_LAST - rx_bit_i)];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            backplane_data_out_o <= 1'b0;
        end else if (rx_bit_en_i) begin
            backplane_data_out_o <= bp_out_nxt;
        end
    end

    // ============================================================
    // Time slot zero NFAS byte
    logic alarm_bit;
    logic [4:0] dl_sel;
    logic nfas_bit;
    logic dl_take;

    // With automatic control off the written alarm bit is ignored.
    assign alarm_bit = auto_remote_alarm_ctl ? tx_remote_alarm : tx_auto_alarm_i;

    // Transparent mode overrides software link selection with the first spare bit.
    assign dl_sel = tx_transparent_mode ? `ELC_DL_TRANSPARENT
                                        : spare_bit_link_select;

    elc_ts0_build u_ts0 (
        .bit_idx_i(tx_bit_i),
        .si_bit_i(tx_si_bit_i),
        .alarm_bit_i(alarm_bit),
        .national_i(tx_national_bits),
        .dl_sel_i(dl_sel),
        .dl_bit_i(dl_bit_i),
        .nfas_bit_o(nfas_bit),
        .dl_take_o(dl_take)
    );

    // ============================================================
    // Transmit bit source selection
    elc_pkg::elc_src_type tx_src;

    always_comb begin
        tx_src = elc_pkg::ELC_SRC_BP;
        if (tx_ts_i == `ELC_TS_ALIGN) begin
            tx_src = tx_nfas_frame_i ? elc_pkg::ELC_SRC_NFAS : elc_pkg::ELC_SRC_FAS;
        end else if (tx_ts_i == `ELC_TS_SIG && !tx_common_channel_mode) begin
            // Associated signalling owns slot 16 even under payload loopback.
            tx_src = elc_pkg::ELC_SRC_SIG;
        end else if (payload_loopback) begin
            tx_src = elc_pkg::ELC_SRC_LOOP;
        end
    end

    logic tx_bit_nxt;

    always_comb begin
        tx_bit_nxt = bp_in_s;
        unique case (tx_src)
            elc_pkg::ELC_SRC_BP: tx_bit_nxt = bp_in_s;
            elc_pkg::ELC_SRC_LOOP: tx_bit_nxt = rx_data_bit_i;
            elc_pkg::ELC_SRC_SIG: tx_bit_nxt = tx_sig_bit_i;
            elc_pkg::ELC_SRC_FAS: tx_bit_nxt = tx_fas_bit_i;
            elc_pkg::ELC_SRC_NFAS: tx_bit_nxt = nfas_bit;
            default: tx_bit_nxt = bp_in_s;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_data_bit_o <= 1'b0;
        end else if (tx_bit_en_i) begin
            tx_data_bit_o <= tx_bit_nxt;
        end
    end

    // The link source is told in the same strobe cycle that its bit is used.
    assign dl_take_o = tx_bit_en_i && tx_src == elc_pkg::ELC_SRC_NFAS && dl_take;

    // ============================================================
    // Receive multiframe pulse
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_multiframe_pulse_o <= 1'b0;
        end else begin
            rx_multiframe_pulse_o <= rx_multiframe_pulse_select ? rx_crc_mf_i
                                                                : rx_sig_mf_i;
        end
    end

endmodule : elc_link_ctl

`default_nettype wire

// file: verif/elc_link_ctl_assertions.sv
/*
 * Checker for the E1 loopback and time-slot-zero control slice.
 * Assumes it is bound to elc_link_ctl and shadows the registers from the bus.
 */
`default_nettype none
`include "elc_cfg.svh"

module elc_link_ctl_assertions (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic rx_line_tip_i,
    input wire logic rx_line_ring_i,
    input wire logic tx_enc_tip_i,
    input wire logic tx_enc_ring_i,
    input wire logic tx_line_tip_o,
    input wire logic tx_line_ring_o,
    input wire logic backplane_data_in_i,
    input wire logic backplane_data_out_o,
    input wire logic rx_bit_en_i,
    input wire logic rx_data_bit_i,
    input wire logic tx_bit_en_i,
    input wire logic [4:0] tx_ts_i,
    input wire logic [2:0] tx_bit_i,
    input wire logic tx_nfas_frame_i,
    input wire logic tx_auto_alarm_i,
    input wire logic tx_sig_bit_i,
    input wire logic dl_bit_i,
    input wire logic dl_take_o,
    input wire logic tx_data_bit_o,
    input wire logic tx_common_channel_mode_o,
    input wire logic rx_sig_mf_i,
    input wire logic rx_crc_mf_i,
    input wire logic rx_multiframe_pulse_o
);
    logic [7:0] sig_r, loop_r, nfas_r, mfdl_r, aux_r, rb_val;
    logic ts0_nfas, sa_pos, sa_sel, sa_val, alarm_val, mf_val;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // ============================================================
    // Register shadow
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sig_r <= 8'h00;
            loop_r <= 8'h00;
            nfas_r <= 8'h00;
            mfdl_r <= 8'h00;
            aux_r <= 8'h00;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                8'h14: sig_r <= reg_wdata_i & 8'h20;
                8'h15: loop_r <= reg_wdata_i & 8'h07;
                8'h16: nfas_r <= reg_wdata_i & 8'h7F;
                8'h17: mfdl_r <= reg_wdata_i & 8'h5F;
                8'h1F: aux_r <= reg_wdata_i & 8'h03;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (reg_addr_i)
            8'h14: rb_val = sig_r;
            8'h15: rb_val = loop_r;
            8'h16: rb_val = nfas_r;
            8'h17: rb_val = mfdl_r;
            8'h1F: rb_val = aux_r;
            default: rb_val = 8'h00;
        endcase
    end

    assign ts0_nfas = tx_bit_en_i && tx_ts_i == 5'h00 && tx_nfas_frame_i;
    assign sa_pos = tx_bit_i >= 3'h3;
    assign sa_sel = aux_r[1] ? (tx_bit_i == 3'h3) : mfdl_r[3'h7 - tx_bit_i];
    assign sa_val = sa_sel ? dl_bit_i : nfas_r[3'h7 - tx_bit_i];
    assign alarm_val = aux_r[0] ? nfas_r[5] : tx_auto_alarm_i;
    assign mf_val = mfdl_r[6] ? rx_crc_mf_i : rx_sig_mf_i;

    // ============================================================
    // Properties
    a_read_back_value: assert property (reg_rd_i |=> reg_rdata_o == $past(rb_val))
        else $error("read data differs from register contents");
    a_idle_rdata_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_remote_loop_on: assert property (loop_r[2] && $past(loop_r[2], 3) |->
        {tx_line_tip_o, tx_line_ring_o} == $past({rx_line_tip_i, rx_line_ring_i}, 3))
        else $error("remote loopback path wrong");
    a_remote_loop_off: assert property (!loop_r[2] && !$past(loop_r[2]) && $past(rstn_i)
        |-> {tx_line_tip_o, tx_line_ring_o} == $past({tx_enc_tip_i, tx_enc_ring_i}))
        else $error("encoder path wrong");
    a_backplane_loop_path: assert property (loop_r[1] && rx_bit_en_i |=>
        backplane_data_out_o == $past(backplane_data_in_i, 3)) else $error("backplane loop wrong");
    a_rx_pass_through: assert property (!loop_r[1] && !nfas_r[6] && rx_bit_en_i |=>
        backplane_data_out_o == $past(rx_data_bit_i)) else $error("receive data not passed");
    a_payload_loop_path: assert property (loop_r[0] && tx_bit_en_i &&
        tx_ts_i != 5'h00 && (tx_ts_i != 5'h10 || sig_r[5]) |=>
        tx_data_bit_o == $past(rx_data_bit_i)) else $error("payload loop data wrong");
    a_cas_slot_sig: assert property (tx_bit_en_i && tx_ts_i == 5'h10 &&
        !sig_r[5] |=> tx_data_bit_o == $past(tx_sig_bit_i)) else $error("slot 16 signalling wrong");
    a_alarm_bit_src: assert property (ts0_nfas && tx_bit_i == 3'h2 |=>
        tx_data_bit_o == $past(alarm_val)) else $error("alarm bit wrong");
    a_spare_bit_src: assert property (ts0_nfas && sa_pos |=>
        tx_data_bit_o == $past(sa_val)) else $error("spare bit wrong");
    a_link_take_now: assert property (dl_take_o ==
        (ts0_nfas && sa_pos && sa_sel)) else $error("data link take wrong");
    a_mf_pulse_follow: assert property ($past(rstn_i) |->
        rx_multiframe_pulse_o == $past(mf_val)) else $error("multiframe pulse wrong");
    a_ccs_mode_level: assert property (tx_common_channel_mode_o == sig_r[5])
        else $error("common channel mode level wrong");

    c_payload: cover property (loop_r[0] && tx_bit_en_i);
    c_link_take: cover property (ts0_nfas && sa_sel);
    c_remote: cover property (loop_r[2] && $past(loop_r[2], 3));
    c_nfas_only: cover property (nfas_r[6] && rx_bit_en_i);
endmodule : elc_link_ctl_assertions

bind elc_link_ctl elc_link_ctl_assertions elc_link_ctl_assertions_inst (.*);

`default_nettype wire

// file: verif/elc_line_model.sv
/*
 * Line interface and backplane partner: drives receive pins, encoder pins,
 * backplane input and multiframe pulses with patterns that change often.
 * Assumes the same clock as the block.
 */
`default_nettype none

module elc_line_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    output logic rx_line_tip_o,
    output logic rx_line_ring_o,
    output logic tx_enc_tip_o,
    output logic tx_enc_ring_o,
    output logic backplane_data_o,
    output logic rx_sig_mf_o,
    output logic rx_crc_mf_o
);
    logic [4:0] cnt_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 5'h00;
        end else begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

    // Receive marks alternate between tip and ring; on each pin pair tip and ring are never high together.
    assign rx_line_tip_o = cnt_r[0] & cnt_r[1];
    assign rx_line_ring_o = cnt_r[0] & ~cnt_r[1];
    assign tx_enc_tip_o = ~cnt_r[0] & cnt_r[2];
    assign tx_enc_ring_o = ~cnt_r[0] & ~cnt_r[2];
    assign backplane_data_o = cnt_r[1] ^ cnt_r[3];
    assign rx_sig_mf_o = cnt_r == 5'h03;
    assign rx_crc_mf_o = cnt_r[3:0] == 4'h9;
endmodule : elc_line_model

`default_nettype wire

// file: verif/testbench.sv
/*
 * Self-checking bench for elc_link_ctl: register bus and bit stream tasks.
 * Assumes elc_line_model supplies the pin-side traffic.
 */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
    logic rx_bit_en_i = 1'b0, rx_nfas_frame_i = 1'b0, rx_data_bit_i = 1'b0;
    logic tx_bit_en_i = 1'b0, tx_nfas_frame_i = 1'b0, tx_fas_bit_i = 1'b0, tx_si_bit_i = 1'b0;
    logic tx_auto_alarm_i = 1'b0, tx_sig_bit_i = 1'b0, dl_bit_i = 1'b0;
    logic [4:0] rx_ts_i = 5'h00, tx_ts_i = 5'h00;
    logic [2:0] rx_bit_i = 3'h0, tx_bit_i = 3'h0;
    logic rx_line_tip_i, rx_line_ring_i, tx_enc_tip_i, tx_enc_ring_i, backplane_data_in_i;
    logic rx_sig_mf_i, rx_crc_mf_i, tx_line_tip_o, tx_line_ring_o, backplane_data_out_o;
    logic dl_take_o, tx_data_bit_o, tx_common_channel_mode_o, rx_multiframe_pulse_o;
    logic [7:0] reg_rdata_o;
    logic [7:0] ofs [6] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h1F, 8'h18};
    logic [7:0] msk [6] = '{8'h20, 8'h07, 8'h7F, 8'h5F, 8'h03, 8'h00};
    logic [7:0] nb = 8'hA5;
    logic [4:0] nat = 5'h0A, sel;
    logic sab, exp;
    int error_cnt = 0, checked = 0, cycles = 0;

    elc_link_ctl elc_link_ctl_inst (.*);

    elc_line_model elc_line_model_inst (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .rx_line_tip_o(rx_line_tip_i),
        .rx_line_ring_o(rx_line_ring_i),
        .tx_enc_tip_o(tx_enc_tip_i),
        .tx_enc_ring_o(tx_enc_ring_i),
        .backplane_data_o(backplane_data_in_i),
        .rx_sig_mf_o(rx_sig_mf_i),
        .rx_crc_mf_o(rx_crc_mf_i)
    );

    always #4 clk_i = ~clk_i;

    // ============================================================
    // Tasks
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, want, seen);
        end
    endtask : check

    task automatic wrap_up();
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        // The data launched by the strobe edge are read here before this edge clears them.
        @(posedge clk_i);
        check("reg_rdata", reg_rdata_o, want);
    endtask : rd

    task automatic tx(input logic [4:0] ts, input logic [2:0] b, input logic nf,
                      input logic want, input logic take);
        tx_ts_i <= ts;
        tx_bit_i <= b;
        tx_nfas_frame_i <= nf;
        tx_bit_en_i <= 1'b1;
        #1;
        check("dl_take", dl_take_o, take);
        @(posedge clk_i);
        tx_bit_en_i <= 1'b0;
        @(posedge clk_i);
        check("tx_data", tx_data_bit_o, want);
    endtask : tx

    task automatic rx(input logic [4:0] ts, input logic [2:0] b, input logic nf,
                      input logic d, input logic want, input logic cmp);
        rx_ts_i <= ts;
        rx_bit_i <= b;
        rx_nfas_frame_i <= nf;
        rx_data_bit_i <= d;
        rx_bit_en_i <= 1'b1;
        @(posedge clk_i);
        rx_bit_en_i <= 1'b0;
        @(posedge clk_i);
        if (cmp) check("bp_out", backplane_data_out_o, want);
    endtask : rx

    // A hang is cut short well beyond the roughly 250 cycles the sequence needs.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ============================================================
    // Sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], 8'h00);
            wr(ofs[i], 8'hFF);
            rd(ofs[i], msk[i]);
            wr(ofs[i], 8'h00);
        end
        wr(8'h15, 8'h04);
        repeat (20) @(posedge clk_i);
        wr(8'h15, 8'h02);
        for (int i = 0; i < 8; i++) rx(5'h05, i[2:0], 1'b0, 1'b0, 1'b0, 1'b0);
        wr(8'h15, 8'h01);
        rx_data_bit_i <= 1'b1;
        tx(5'h03, 3'h4, 1'b0, 1'b1, 1'b0);
        rx_data_bit_i <= 1'b0;
        tx(5'h03, 3'h4, 1'b0, 1'b0, 1'b0);
        tx_sig_bit_i <= 1'b1;
        tx(5'h10, 3'h0, 1'b0, 1'b1, 1'b0);
        wr(8'h14, 8'h20);
        tx(5'h10, 3'h0, 1'b0, 1'b0, 1'b0);
        tx_fas_bit_i <= 1'b1;
        tx(5'h00, 3'h1, 1'b0, 1'b1, 1'b0);
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h00);
        wr(8'h16, 8'h2A);
        wr(8'h17, 8'h05);
        dl_bit_i <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            wr(8'h1F, m[7:0]);
            for (int i = 0; i < 8; i++) begin
                sel = (m == 2) ? 5'h10 : 5'h05;
                sab = i > 2 && sel[7 - i];
                exp = i == 1 ? 1'b1 : i == 2 ? (m == 1) : i == 0 ? 1'b0 : sab ? 1'b1 : nat[7 - i];
                tx(5'h00, i[2:0], 1'b1, exp, sab);
            end
        end
        wr(8'h16, 8'h40);
        for (int i = 0; i < 8; i++) rx(5'h00, i[2:0], 1'b1, nb[7 - i], 1'b0, 1'b0);
        for (int i = 0; i < 8; i++) rx(5'h00, i[2:0], 1'b0, 1'b0, nb[7 - i], 1'b1);
        wr(8'h16, 8'h00);
        rx(5'h00, 3'h0, 1'b0, 1'b1, 1'b1, 1'b1);
        wr(8'h17, 8'h40);
        repeat (40) @(posedge clk_i);
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
